/* File: design/pild_decoder.sv */
// Purpose: executes port reads, pointer increment and immediate accumulator loads
// Assumes: one instruction offered per machine cycle via instr.valid
// Notes: skip_next tells the fetch unit the next valid instruction is suppressed

`default_nettype none

module pild_decoder (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // instruction from fetch
  input wire pild_pkg::pild_instr_t instr,
  // port pins, asynchronous to the core
  input wire logic [3:0] first_general_port,
  input wire logic [1:0] second_general_port,
  // results to the core
  output pild_pkg::pild_state_t state,
  output logic skip_next,
  output logic executed
);
  import pild_pkg::*;

  // pin synchronisers; stage one is read only by stage two
  logic [3:0] p1_meta_ff, p1_sync_ff; // first port, both stages
  logic [1:0] p2_meta_ff, p2_sync_ff; // second port, both stages
  logic [3:0] nxt_p1_meta, nxt_p1_sync; // next first port stages
  logic [1:0] nxt_p2_meta, nxt_p2_sync; // next second port stages

  // architectural state and sequencing flags
  logic [3:0] acc_ff, nxt_acc; // accumulator
  logic [3:0] ptr_ff, nxt_ptr; // column pointer
  logic skip_ff, nxt_skip; // suppress the next valid instruction
  logic last_load_ff, nxt_last_load; // previous instruction was a load

  // decoded instruction kinds
  logic is_rd1; // read of the first port
  logic is_rd2; // read of the second port
  logic is_bump; // column pointer increment
  logic is_load; // immediate load, any nibble
  logic run; // valid and not suppressed by a skip

  // synchroniser next values; the pins may move at any time, so no
  // logic looks at them before the second stage
  always_comb begin
    nxt_p1_meta = first_general_port;
    nxt_p1_sync = p1_meta_ff;
    nxt_p2_meta = second_general_port;
    nxt_p2_sync = p2_meta_ff;
  end

  // synchroniser registers; reset low so a port read right after
  // reset sees a defined value rather than stale pin history
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      // pins read as all low while reset is held
      p1_meta_ff <= NIB_ZERO;
      p1_sync_ff <= NIB_ZERO;
      p2_meta_ff <= HI_ZERO;
      p2_sync_ff <= HI_ZERO;
    end else begin
      // one stage per clock, two clocks of latency in all
      p1_meta_ff <= nxt_p1_meta;
      p1_sync_ff <= nxt_p1_sync;
      p2_meta_ff <= nxt_p2_meta;
      p2_sync_ff <= nxt_p2_sync;
    end
  end

  // opcode decode; the load compares only the upper six bits, since
  // the low nibble carries the immediate value
  always_comb begin
    is_rd1 = instr.opcode == OP_READ_FIRST_PORT;
    is_rd2 = instr.opcode == OP_READ_SECOND_PORT;
    is_bump = instr.opcode == OP_BUMP_COLUMN_PTR;
    is_load = instr.opcode[OP_W-1:OPC_HI_LSB] == OP_LOAD_ACC_HI;
    // a valid instruction runs unless skipped by the prior one
    run = instr.valid && !skip_ff;
  end

  // next-state computation
  // trade-off: a port read uses pin levels two cycles old, which costs
  // latency but keeps metastable values out of the accumulator
  always_comb begin
    // hold everything unless the instruction says otherwise
    nxt_acc = acc_ff;
    nxt_ptr = ptr_ff;
    nxt_skip = skip_ff;
    nxt_last_load = last_load_ff;
    if (instr.valid) begin
      // a skipped slot still counts for the load run
      nxt_skip = 1'b0;
      nxt_last_load = is_load;
      if (run) begin
        // only one branch fires, since the opcodes are disjoint
        if (is_rd1) begin
          // all four pins land in the accumulator
          nxt_acc = p1_sync_ff;
        end else if (is_rd2) begin
          // two pins in the low bits, high bits forced low
          nxt_acc = {HI_ZERO, p2_sync_ff};
        end else if (is_bump) begin
          // the four-bit add wraps from fifteen to zero by itself
          nxt_ptr = ptr_ff + NIB_ONE;
          // a zero result asks the fetch side to drop the next word
          nxt_skip = (ptr_ff + NIB_ONE) == NIB_ZERO;
        end else if (is_load) begin
          // immediate nibble straight from the opcode
          nxt_acc = instr.opcode[IMM_MSB:IMM_LSB];
          nxt_skip = 1'b0;
        end else begin
          // unknown opcodes change nothing but still end a load run
          nxt_acc = acc_ff;
        end
      end
      // a load after a load is treated as skipped, even when the
      // earlier load was itself skipped
      if (is_load && last_load_ff) begin
        nxt_acc = acc_ff;
      end
    end
    // idle cycles keep skip and load-run state, so a gap never breaks a run
  end

  // state registers; reset gives a zero accumulator and pointer
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      // no pending skip and no open load run after reset
      acc_ff <= ACC_RST;
      ptr_ff <= PTR_RST;
      skip_ff <= 1'b0;
      last_load_ff <= 1'b0;
    end else begin
      // plain registering, all decisions are made above
      acc_ff <= nxt_acc;
      ptr_ff <= nxt_ptr;
      skip_ff <= nxt_skip;
      last_load_ff <= nxt_last_load;
    end
  end

  // outputs; state comes straight from flip-flops, executed is a
  // same-cycle handshake the fetch side may use for tracing
  always_comb begin
    state.acc = acc_ff;
    state.ptr = ptr_ff;
    // level until the next valid instruction consumes it
    skip_next = skip_ff;
    // executed: this valid instruction takes effect
    executed = run && !(is_load && last_load_ff);
  end

  // checks next to the logic; all run on the one core clock and
  // are switched off while reset is held low

  // port reads
  chk_rd1_copy: assert property (@(posedge clock) disable iff (!arst_n)
    run && is_rd1 |=> acc_ff == $past(p1_sync_ff))
    else $error("first port read did not load accumulator");
  chk_rd2_high: assert property (@(posedge clock) disable iff (!arst_n)
    run && is_rd2 |=> acc_ff == {HI_ZERO, $past(p2_sync_ff)})
    else $error("second port read wrong");
  chk_rd_noskip: assert property (@(posedge clock) disable iff (!arst_n)
    run && (is_rd1 || is_rd2 || is_load) |=> !skip_ff)
    else $error("read or load raised the skip flag");
  chk_exec_run: assert property (@(posedge clock) disable iff (!arst_n)
    instr.valid && !skip_ff && !is_load |-> executed)
    else $error("unskipped instruction not executed");

  // pointer increment and its skip
  chk_bump_add: assert property (@(posedge clock) disable iff (!arst_n)
    run && is_bump |=> ptr_ff == NIB_W'($past(ptr_ff) + NIB_ONE))
    else $error("pointer increment wrong");
  chk_ptr_hold: assert property (@(posedge clock) disable iff (!arst_n)
    !(run && is_bump) |=> $stable(ptr_ff))
    else $error("pointer changed without increment");
  chk_skip_zero: assert property (@(posedge clock) disable iff (!arst_n)
    run && is_bump |=> skip_ff == (ptr_ff == NIB_ZERO))
    else $error("skip flag does not follow wrap");
  chk_bump_noskip: assert property (@(posedge clock) disable iff (!arst_n)
    run && is_bump && ptr_ff != ~NIB_ZERO |=> !skip_ff)
    else $error("skip raised without wrap");

  // skipped slots and idle cycles
  chk_skip_block: assert property (@(posedge clock) disable iff (!arst_n)
    skip_ff && instr.valid |=> $stable(acc_ff) && $stable(ptr_ff) && !skip_ff)
    else $error("skipped instruction took effect");
  chk_exec_skip: assert property (@(posedge clock) disable iff (!arst_n)
    skip_ff && instr.valid |-> !executed)
    else $error("skipped instruction flagged as executed");
  chk_skip_idle: assert property (@(posedge clock) disable iff (!arst_n)
    !instr.valid |=> $stable(skip_ff) && $stable(acc_ff) && $stable(ptr_ff))
    else $error("idle cycle changed state");

  // immediate loads and load runs
  chk_load_imm: assert property (@(posedge clock) disable iff (!arst_n)
    run && is_load && !last_load_ff |=> acc_ff == $past(instr.opcode[IMM_MSB:IMM_LSB]))
    else $error("immediate load wrong");
  chk_load_run: assert property (@(posedge clock) disable iff (!arst_n)
    instr.valid && is_load ##1 instr.valid && is_load |=> $stable(acc_ff))
    else $error("second load in run took effect");
  chk_exec_load: assert property (@(posedge clock) disable iff (!arst_n)
    instr.valid && is_load && last_load_ff |-> !executed)
    else $error("later load in run flagged as executed");
  chk_load_flag: assert property (@(posedge clock) disable iff (!arst_n)
    instr.valid |=> last_load_ff == $past(is_load))
    else $error("load run flag wrong");

  // anything else leaves the accumulator alone
  chk_other_hold: assert property (@(posedge clock) disable iff (!arst_n)
    run && !(is_rd1 || is_rd2 || is_load) |=> $stable(acc_ff))
    else $error("non-load instruction changed accumulator");

endmodule

`default_nettype wire

/* File: design/pild_pkg.sv */
// Purpose: shared constants and types for the port-input and load decoder
// Assumes: 10-bit opcodes, 4-bit accumulator and column pointer
// Notes: opcode values are the hexadecimal instruction codes

package pild_pkg;

  // opcode width and data widths
  localparam int OP_W = 10;
  localparam int NIB_W = 4;

  // full opcodes of the fixed instructions
  localparam logic [9:0] OP_READ_FIRST_PORT = 10'h261;
  localparam logic [9:0] OP_READ_SECOND_PORT = 10'h262;
  localparam logic [9:0] OP_BUMP_COLUMN_PTR = 10'h013;

  // immediate load: upper six bits fixed, low nibble is the value
  localparam logic [5:0] OP_LOAD_ACC_HI = 6'h07;
  localparam int IMM_LSB = 0;
  localparam int IMM_MSB = 3;
  localparam int OPC_HI_LSB = 4;

  // reset values and fixed constants
  localparam logic [3:0] ACC_RST = 4'h0;
  localparam logic [3:0] PTR_RST = 4'h0;
  localparam logic [3:0] NIB_ONE = 4'h1;
  localparam logic [3:0] NIB_ZERO = 4'h0;
  localparam logic [1:0] HI_ZERO = 2'h0;

  // fetched instruction as presented by the fetch unit
  typedef struct packed {
    logic valid;
    logic [9:0] opcode;
  } pild_instr_t;

  // architectural state seen by the rest of the core
  typedef struct packed {
    logic [3:0] acc;
    logic [3:0] ptr;
  } pild_state_t;

endpackage

/* File: verification/pild_fetch_model.sv */
// Purpose: fetch unit and port pin model
// Assumes: calls are made from clocked bench code
// Notes: valid is dropped when idle
`default_nettype none
module pild_fetch_model (
  // clock
  input wire logic clock,
  // to decoder
  output var pild_pkg::pild_instr_t instr,
  output logic [3:0] pin1,
  output logic [1:0] pin2
);
  timeunit 1ns;
  timeprecision 1ns;
  initial instr = '0;
  initial pin1 = 4'h0;
  initial pin2 = 2'h0;
  // one opcode per edge, held until the next edge
  task issue(input logic [9:0] op);
    @(posedge clock);
    instr <= {1'b1, op};
  endtask
  // new pin levels, launched on an edge; the decoder sees them two edges later
  task set_pins(input logic [3:0] a, input logic [1:0] b);
    @(posedge clock);
    pin1 <= a;
    pin2 <= b;
  endtask
  // idle cycle, so the decoder state settles
  task idle;
    @(posedge clock);
    instr <= '0;
  endtask
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Purpose: self-checking bench for the decoder
// Assumes: pins are held stable past the sync delay
// Notes: state and skip are read one cycle after the op, executed in the op's own cycle
`default_nettype none
module tb_top import pild_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0;
  logic arst_n = 0;
  pild_instr_t instr;
  logic [3:0] pin1;
  logic [1:0] pin2;
  pild_state_t st;
  logic skip;
  logic exe;
  int num_errors = 0;
  int samples_checked = 0;
  always #20 clock = ~clock;
  pild_fetch_model fm (.clock(clock), .instr(instr), .pin1(pin1), .pin2(pin2));
  pild_decoder pild_decoder_i (.clock(clock), .arst_n(arst_n), .instr(instr),
    .first_general_port(pin1), .second_general_port(pin2),
    .state(st), .skip_next(skip), .executed(exe));
  // compare one nibble
  task chk(input string n, input logic [3:0] e, input logic [3:0] s);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  // let the op land, then look
  task settle;
    fm.idle;
    #1;
  endtask
  task report_and_stop;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // pins must pass the two-flop sync first
  task s_port1;
    fm.set_pins(4'hA, 2'h0);
    repeat (2) @(posedge clock);
    fm.issue(10'h261);
    #1;
    chk("exe p1", 4'h1, {3'h0, exe});
    settle;
    chk("acc p1", 4'hA, st.acc);
    chk("skip p1", 4'h0, {3'h0, skip});
  endtask
  // fifteen bumps, then the wrap and its skip
  task s_bump;
    repeat (15) fm.issue(10'h013);
    settle;
    chk("ptr F", 4'hF, st.ptr);
    chk("no skip", 4'h0, {3'h0, skip});
    fm.issue(10'h013);
    settle;
    chk("ptr wrap", 4'h0, st.ptr);
    chk("skip", 4'h1, {3'h0, skip});
    fm.issue(10'h07C);
    #1;
    chk("exe skip", 4'h0, {3'h0, exe});
    settle;
    chk("acc kept", 4'hA, st.acc);
    chk("skip off", 4'h0, {3'h0, skip});
    fm.issue(10'h075);
    #1;
    chk("exe ld after skipped ld", 4'h0, {3'h0, exe});
    settle;
    chk("acc after skipped run", 4'hA, st.acc);
  endtask
  // a run of loads: only the first counts
  task s_load;
    fm.issue(10'h000);
    fm.issue(10'h075);
    #1;
    chk("exe ld", 4'h1, {3'h0, exe});
    fm.issue(10'h07A);
    #1;
    chk("exe run", 4'h0, {3'h0, exe});
    settle;
    chk("acc ld", 4'h5, st.acc);
  endtask
  // high accumulator bits cleared
  task s_port2;
    fm.set_pins(4'hA, 2'h2);
    repeat (2) @(posedge clock);
    fm.issue(10'h262);
    settle;
    chk("acc p2", 4'h2, st.acc);
  endtask
  initial begin
    repeat (4) @(posedge clock);
    chk("rst acc", ACC_RST, st.acc);
    arst_n <= 1'b1;
    s_port1;
    s_bump;
    s_load;
    s_port2;
    report_and_stop;
  end
endmodule
`default_nettype wire
